// file: src/sbt_pkg.sv
// Package for the boundary scan test port: codes, field layouts, map.
// Assumes a single system clock that oversamples the test clock pin.
package sbt_pkg;

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  localparam int IR_W = 3;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPZ = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  // ****************************************************************
  // Identification word layout
  // ****************************************************************
  localparam int ID_W = 32;
  localparam int ID_REV_LSB = 29;
  localparam int ID_DEV_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  localparam logic ID_PRESENT = 1'b1;

  // ****************************************************************
  // Boundary chain
  // ****************************************************************
  localparam int BSR_LEN_DEF = 89;
  localparam int BSR_OE_CELL_DEF = 89;

  // ****************************************************************
  // Register map, byte offsets
  // ****************************************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_ID = 4'h8;
  localparam int CTRL_TAP_RESET = 0;
  localparam logic CTRL_RESET_VAL = 1'b0;

  // ****************************************************************
  // Carriers and states
  // ****************************************************************
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_pins_t;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } sbt_state_t;

  typedef struct packed {
    logic tdo_oe;
    logic [2:0] instr;
    logic [3:0] state;
  } sbt_status_t;

endpackage

// file: src/sbt_tap.sv
// Test access port of a pipelined memory: TAP controller, instruction,
// bypass, identification and boundary registers, Avalon-MM status port.
// Assumes test pins arrive from outside and are oversampled by i_clock.
// Assumes each TCK phase lasts at least two i_clock cycles.
// Only pin controls reach the memory; its array lives elsewhere.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sbt_tap #(
  parameter int BSR_LEN = sbt_pkg::BSR_LEN_DEF,
  parameter int BSR_OE_CELL = sbt_pkg::BSR_OE_CELL_DEF,
  parameter logic [2:0] ID_REV = 3'h0,
  parameter logic [16:0] ID_DEVICE = 17'h00ABC, // Value is arbitrary
  parameter logic [10:0] ID_MAKER = 11'h155 // Value is arbitrary
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  // Avalon-MM slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Test pins
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  // I/O ring
  input wire logic [BSR_LEN-1:0] i_ring,
  output logic [BSR_LEN-1:0] o_cell_drive,
  output logic o_extest,
  output logic o_q_drive_en
);
  import sbt_pkg::*;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // Refuse chains without room for the enable cell
  generate
    if (BSR_OE_CELL < 1 || BSR_OE_CELL > BSR_LEN || BSR_LEN < 2)
    begin : g_bad
      $error("boundary chain length or enable cell out of range");
    end
  endgenerate

  // Identification fields must tile the word exactly
  generate
    if (ID_MFR_LSB + $bits(ID_MAKER) != ID_DEV_LSB ||
        ID_DEV_LSB + $bits(ID_DEVICE) != ID_REV_LSB ||
        ID_REV_LSB + $bits(ID_REV) != ID_W)
    begin : g_bad_id
      $error("identification fields do not tile the word");
    end
  endgenerate

  localparam int OE_IDX = BSR_OE_CELL - 1;
  localparam logic [ID_W-1:0] ID_WORD =
    {ID_REV, ID_DEVICE, ID_MAKER, ID_PRESENT};

  // ****************************************************************
  // Pin synchronisers and test clock edges
  // ****************************************************************
  sbt_pins_t pin_s1;
  sbt_pins_t pin_s2;
  logic tck_q;
  logic ctrl_tap_reset;

  // Two stages before any use
  // All three pins share one delay, so TMS and TDI stay aligned to TCK
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      tck_q <= 1'b0;
    end
    else
    begin
      pin_s1 <= '{tck: i_tck, tms: i_tms, tdi: i_tdi};
      pin_s2 <= pin_s1;
      tck_q <= pin_s2.tck;
    end
  end

  // Edges and data taken from the same delayed sample
  wire tck_rise = pin_s2.tck & ~tck_q;
  wire tck_fall = ~pin_s2.tck & tck_q;
  wire tms = pin_s2.tms;
  wire tdi = pin_s2.tdi;

  // ****************************************************************
  // TAP controller
  // ****************************************************************
  sbt_state_t state;
  sbt_state_t next_state;

  // Standard transitions on sampled TMS
  // Five TMS-high rises reach Test-Logic-Reset from every state
  always_comb
  begin
    case (state)
      ST_TLR: next_state = tms ? ST_TLR : ST_RTI;
      ST_RTI: next_state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: next_state = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_state = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: next_state = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end

  // State advances only on test clock rise
  // Soft reset holds the controller in Test-Logic-Reset
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn || ctrl_tap_reset)
      state <= ST_TLR;
    else if (tck_rise)
      state <= next_state;
  end

  // ****************************************************************
  // State decode
  // ****************************************************************
  // One wire per state that other logic acts on
  wire in_tlr = (state == ST_TLR);
  wire in_cap_ir = (state == ST_CAP_IR);
  wire in_sh_ir = (state == ST_SH_IR);
  wire in_upd_ir = (state == ST_UPD_IR);
  wire in_cap_dr = (state == ST_CAP_DR);
  wire in_sh_dr = (state == ST_SH_DR);
  wire in_upd_dr = (state == ST_UPD_DR);

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  logic [IR_W-1:0] ir_shift;
  logic [IR_W-1:0] instr;

  // Capture, shift, update; reset reloads IDCODE
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn || in_tlr)
    begin
      ir_shift <= IR_CAPTURE;
      instr <= IR_IDCODE;
    end
    else if (tck_rise)
    begin
      if (in_cap_ir)
        ir_shift <= IR_CAPTURE;
      else if (in_sh_ir)
        ir_shift <= {tdi, ir_shift[IR_W-1:1]};
      else if (in_upd_ir)
        instr <= ir_shift;
    end
  end

  // Decode; reserved codes fall back to bypass
  // Current instruction only, never the shifter contents
  wire is_extest = (instr == IR_EXTEST);
  wire is_sampz = (instr == IR_SAMPZ);
  wire is_sample = (instr == IR_SAMPLE);
  wire sel_id = (instr == IR_IDCODE);
  wire sel_bsr = is_extest | is_sampz | is_sample;
  wire sel_byp = ~sel_id & ~sel_bsr;

  // ****************************************************************
  // Data registers
  // ****************************************************************
  logic bypass_bit;
  logic [ID_W-1:0] id_shift;
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_latch;

  // Data register strobes on test clock rise
  wire dr_cap = tck_rise & in_cap_dr;
  wire dr_sh = tck_rise & in_sh_dr;
  wire dr_upd = tck_rise & in_upd_dr;

  // Bypass stage
  // Reserved codes land here too, one register stays in the path
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      bypass_bit <= 1'b0;
    else if (dr_cap && sel_byp)
      bypass_bit <= 1'b0;
    else if (dr_sh && sel_byp)
      bypass_bit <= tdi;
  end

  // Identification shifter
  // Reloaded at reset so a scan straight after reads the word
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      id_shift <= ID_WORD;
    else if (dr_cap && sel_id)
      id_shift <= ID_WORD;
    else if (dr_sh && sel_id)
      id_shift <= {tdi, id_shift[ID_W-1:1]};
  end

  // Boundary shifter: ring snapshot, memory path untouched
  // Capture only samples the ring; no pin is driven from here
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      bsr_shift <= '0;
    else if (dr_cap && sel_bsr)
      bsr_shift <= i_ring;
    else if (dr_sh && sel_bsr)
      bsr_shift <= {tdi, bsr_shift[BSR_LEN-1:1]};
  end

  // Latched cell outputs; enable cell preset high on reset
  // Latches move only at Update-DR and Test-Logic-Reset, so shifting never disturbs pins
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn || in_tlr)
    begin
      bsr_latch <= '0;
      bsr_latch[OE_IDX] <= 1'b1;
    end
    else if (dr_upd && sel_bsr)
      bsr_latch <= bsr_shift;
  end

  // Serial source of the selected register
  wire dr_lsb = sel_bsr ? bsr_shift[0] : (sel_id ? id_shift[0] : bypass_bit);
  wire next_tdo = in_sh_ir ? ir_shift[0] : dr_lsb;
  wire next_tdo_oe = in_sh_ir | in_sh_dr;

  // ****************************************************************
  // TDO on test clock fall
  // ****************************************************************
  // Changed after the fall so the host finds them settled at the rise
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      o_tdo <= next_tdo;
      o_tdo_oe <= next_tdo_oe;
    end
  end

  // ****************************************************************
  // Memory pin controls
  // ****************************************************************
  // Sample Z wins; EXTEST obeys the latched enable cell
  wire next_q_en = is_sampz ? 1'b0 : (is_extest ? bsr_latch[OE_IDX] : 1'b1);

  // Registered steering of ring drivers
  // Registered so the memory sees clean enables
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_cell_drive <= '0;
      o_extest <= 1'b0;
      o_q_drive_en <= 1'b1;
    end
    else
    begin
      o_cell_drive <= bsr_latch;
      o_extest <= is_extest;
      o_q_drive_en <= next_q_en;
    end
  end

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // Status word gathered for software
  sbt_status_t status;
  assign status = '{tdo_oe: o_tdo_oe, instr: instr, state: state};

  // Access decode; waitrequest low marks the answering cycle
  wire acc = (i_read | i_write) & o_waitrequest;
  wire wr_done = i_write & ~o_waitrequest;
  wire hit_ctrl = (i_address == OFS_CTRL);
  wire hit_status = (i_address == OFS_STATUS);
  wire hit_id = (i_address == OFS_ID);

  // Read value per register, then pick by address
  wire [31:0] rd_ctrl = {31'h0, ctrl_tap_reset};
  wire [31:0] rd_status = {24'h0, status};
  wire [31:0] rd_id = ID_WORD;
  wire [31:0] next_readdata =
    hit_ctrl ? rd_ctrl :
    hit_status ? rd_status :
    hit_id ? rd_id : 32'h0;

  // One wait state per access
  // Read data loads in the cycle waitrequest falls
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h0;
    end
    else
    begin
      o_waitrequest <= ~acc;
      if (acc && i_read)
        o_readdata <= next_readdata;
    end
  end

  // Control register write
  // Writing one holds the TAP in reset until software clears it
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      ctrl_tap_reset <= CTRL_RESET_VAL;
    else if (wr_done && hit_ctrl && i_byteenable[0])
      ctrl_tap_reset <= i_writedata[CTRL_TAP_RESET];
  end

endmodule

`default_nettype wire

// file: tb/sbt_tap_assertions.sv
// Checker for the test port: pin timing and reset relations.
// Assumes it is bound onto sbt_tap, pins oversampled by i_clock.
`timescale 1ns/1ps
`default_nettype none
module sbt_tap_assertions #(
  parameter int BSR_LEN = 89,
  parameter int BSR_OE_CELL = 89
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic [BSR_LEN-1:0] o_cell_drive,
  input wire logic o_extest,
  input wire logic o_q_drive_en,
  input wire logic o_waitrequest
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // ****
  // Count test clock rises with TMS high
  // ****
  logic tck_q;
  logic [2:0] hi_cnt;
  logic [2:0] next_hi_cnt;
  wire tck_rise = i_tck && !tck_q;
  assign next_hi_cnt = !tck_rise ? hi_cnt : (!i_tms ? 3'h0 : (hi_cnt == 3'h5 ? 3'h5 : hi_cnt + 3'h1));
  always_ff @(posedge i_clock)
  begin
    tck_q <= i_rstn ? i_tck : 1'b0;
    hi_cnt <= i_rstn ? next_hi_cnt : 3'h0;
  end
  property p_tdo_fall;
    ($changed(o_tdo_oe) || (o_tdo_oe && $changed(o_tdo))) |-> !i_tck && !$past(i_tck, 2);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved outside tck low");
  property p_oe_hold;
    o_tdo_oe && tck_rise && !i_tms |=> o_tdo_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("tdo dropped in shift");
  property p_oe_exit;
    o_tdo_oe && tck_rise && i_tms |-> ##[4:10] !o_tdo_oe;
  endproperty
  a_oe_exit: assert property (p_oe_exit) else $error("tdo driven after shift");
  property p_tlr_ext;
    $rose(hi_cnt == 3'h5) |-> ##[1:8] (!o_extest && !o_tdo_oe);
  endproperty
  a_tlr_ext: assert property (p_tlr_ext) else $error("no reset after five tms");
  property p_tlr_en;
    $rose(hi_cnt == 3'h5) |-> ##[1:8] o_q_drive_en;
  endproperty
  a_tlr_en: assert property (p_tlr_en) else $error("bus enable not set");
  property p_cell_en;
    o_extest && $past(o_extest, 2) && $stable(o_cell_drive) && $past(o_cell_drive, 2) == o_cell_drive
      |-> o_q_drive_en == o_cell_drive[BSR_OE_CELL-1];
  endproperty
  a_cell_en: assert property (p_cell_en) else $error("bus enable not cell");
  property p_rst_oe;
    disable iff (1'b0) !i_rstn |=> !o_tdo_oe;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("tdo driven in reset");
  property p_rst_en;
    disable iff (1'b0) !i_rstn ##1 !i_rstn |=> o_q_drive_en && !o_extest;
  endproperty
  a_rst_en: assert property (p_rst_en) else $error("reset enable wrong");
  // Main scenarios
  cover property (o_extest && !o_q_drive_en);
  cover property ($rose(o_tdo_oe));
  cover property (!o_waitrequest);
endmodule
bind sbt_tap sbt_tap_assertions #(.BSR_LEN(BSR_LEN), .BSR_OE_CELL(BSR_OE_CELL)) i_chk (
  .i_clock, .i_rstn, .i_tck, .i_tms, .o_tdo, .o_tdo_oe, .o_cell_drive, .o_extest,
  .o_q_drive_en, .o_waitrequest);
`default_nettype wire

// file: tb/sbt_jtag_host.sv
// Model of a board test controller driving the test pins.
// Assumes a 40 ns i_clock; the test clock is made from it.
`timescale 1ns/1ps
`default_nettype none
module sbt_jtag_host (
  input wire logic i_clock,
  input wire logic i_tdo,
  output var sbt_pkg::sbt_pins_t o_pins
);
  import sbt_pkg::*;
  // Idle: clock still, data lines at pull-up level
  initial o_pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
  // One test clock of 8 cycles, 320 ns
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_clock);
    o_pins <= '{tck: 1'b0, tms: tms, tdi: tdi};
    repeat (4) @(posedge i_clock);
    tdo = i_tdo;
    o_pins.tck <= 1'b1;
    repeat (3) @(posedge i_clock);
  endtask
  // Scan n bits through IR or DR, ending in idle
  task automatic scan(input logic ir, input int n, input logic [88:0] din,
                      output logic [88:0] dout);
    logic t;
    dout = '0;
    step(1'b0, 1'b1, t);
    step(1'b1, 1'b1, t);
    if (ir)
      step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask
  // Five clocks with TMS high
  task automatic reset5();
    logic t;
    repeat (5) step(1'b1, 1'b1, t);
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench: status port and scans through the test port.
// Assumes sbt_tap, the host model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbt_pkg::*;
  localparam logic [2:0] T_REV = 3'h5; // Values are arbitrary
  localparam logic [16:0] T_DEV = 17'h0F0F1;
  localparam logic [10:0] T_MFR = 11'h2A3;
  localparam logic [88:0] RING = 89'h0_A5A5C3C3_96960F0F_3C3CA5;
  localparam logic [88:0] ID = {57'h0, T_REV, T_DEV, T_MFR, 1'b1};
  logic i_clock, i_rstn, i_read, i_write, o_waitrequest;
  logic o_tdo, o_tdo_oe, o_extest, o_q_drive_en;
  logic [3:0] i_address;
  logic [31:0] i_writedata, o_readdata;
  logic [88:0] o_cell_drive, q, r, pat;
  sbt_pins_t pins;
  int checks = 0;
  int mismatches = 0;
  logic [2:0] codes [3] = '{IR_SAMPLE, IR_SAMPZ, IR_EXTEST};
  // ****
  // Design and far side
  // ****
  sbt_tap #(.ID_REV(T_REV), .ID_DEVICE(T_DEV), .ID_MAKER(T_MFR)) i_sbt_tap (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_tck(pins.tck),
    .i_tms(pins.tms), .i_tdi(pins.tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
    .i_ring(RING), .o_cell_drive(o_cell_drive), .o_extest(o_extest),
    .o_q_drive_en(o_q_drive_en));
  // Undriven TDO shows the inverse of its last value
  sbt_jtag_host i_sbt_jtag_host (.i_clock(i_clock), .i_tdo(o_tdo_oe ? o_tdo : ~o_tdo),
    .o_pins(pins));
  // 25 MHz clock
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // Close the run with the verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compare seen against expected
  task automatic check(input string what, input logic [88:0] seen, input logic [88:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One Avalon access, held until waitrequest is low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [88:0] rd);
    int n;
    @(posedge i_clock);
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= d;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    rd = 89'(o_readdata);
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (n >= 50)
    begin
      mismatches++;
      results();
    end
  endtask
  // Main sequence
  initial
  begin
    i_rstn = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 4'h0;
    i_writedata = 32'h0;
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clock);
    av(1'b0, OFS_STATUS, 32'h0, q);
    check("status", q, 89'h10);
    av(1'b0, OFS_ID, 32'h0, q);
    check("id reg", q, ID);
    av(1'b0, 4'hC, 32'h0, q);
    check("unmapped", q, 89'h0);
    check("cells", o_cell_drive, {1'b1, 88'h0});
    check("flags", 89'({o_extest, o_q_drive_en, o_tdo_oe}), 89'h2);
    $display("test reset values done");
    i_sbt_jtag_host.scan(1'b1, 3, 89'(IR_BYPASS), r);
    check("ir capture", 89'(r[2:0]), 89'(IR_CAPTURE));
    av(1'b0, OFS_STATUS, 32'h0, q);
    check("status", q, 89'h71);
    i_sbt_jtag_host.scan(1'b0, 8, 89'hB4, r);
    check("bypass", 89'(r[7:0]), 89'h68);
    $display("test bypass done");
    i_sbt_jtag_host.reset5();
    av(1'b0, OFS_STATUS, 32'h0, q);
    check("status", q, 89'h10);
    i_sbt_jtag_host.scan(1'b0, 32, 89'h0, r);
    check("idcode", 89'(r[31:0]), ID);
    $display("test idcode done");
    pat = {1'b0, ~RING[87:0]};
    foreach (codes[k])
    begin
      i_sbt_jtag_host.scan(1'b1, 3, 89'(codes[k]), r);
      i_sbt_jtag_host.scan(1'b0, 89, pat, r);
      repeat (2) @(posedge i_clock);
      check("ring", r, RING);
      check("cells", o_cell_drive, pat);
      check("flags", 89'({o_extest, o_q_drive_en}),
            89'({codes[k] == IR_EXTEST, codes[k] == IR_SAMPLE}));
    end
    i_sbt_jtag_host.reset5();
    repeat (4) @(posedge i_clock);
    check("cell oe", 89'(o_cell_drive[88]), 89'h1);
    check("flags", 89'({o_extest, o_q_drive_en}), 89'h1);
    $display("test boundary done");
    i_sbt_jtag_host.scan(1'b1, 3, 89'(IR_BYPASS), r);
    av(1'b1, OFS_CTRL, 32'h1, q);
    repeat (2) @(posedge i_clock);
    av(1'b0, OFS_STATUS, 32'h0, q);
    check("soft reset", q, 89'h10);
    av(1'b1, OFS_CTRL, 32'h0, q);
    $display("test soft reset done");
    results();
  end
endmodule
`default_nettype wire
